// [common/crx_pkg.sv]
// Shared constants and types of the camera lane receiver.
// Assumes lane line states are presented as {positive, negative} pairs.
package crx_pkg;
   // ==================================================================
   // Line states and packet constants
   localparam logic [1:0]  CRX_LP11         = 2'h3;
   localparam logic [1:0]  CRX_LP01         = 2'h1;
   localparam logic [1:0]  CRX_LP00         = 2'h0;
   localparam logic [7:0]  CRX_SYNC_BYTE    = 8'hB8;
   localparam logic [5:0]  CRX_SHORT_DT_MAX = 6'h0F;
   localparam logic [15:0] CRX_CRC_INIT     = 16'hFFFF;
   localparam logic [15:0] CRX_CRC_POLY     = 16'h8408;
   localparam logic [15:0] CRX_HDR_BYTES    = 16'h0004;
   localparam logic [15:0] CRX_CRC_BYTES    = 16'h0002;
   // Lane count codes on the configuration input.
   localparam logic [1:0]  CRX_CFG_1LANE    = 2'h0;
   localparam logic [1:0]  CRX_CFG_2LANE    = 2'h1;
   // ==================================================================
   // Error status bit positions
   localparam int CRX_ST_ECC_CORR = 0;
   localparam int CRX_ST_ECC_DBL  = 1;
   localparam int CRX_ST_CRC      = 2;
   localparam int CRX_ST_SOT      = 3;
   localparam int CRX_ST_SOT_SYNC = 4;
   localparam int CRX_ST_BITS     = 5;
   // Parity pattern of each header data bit, bit 0 first.
   localparam logic [5:0] CRX_ECC_COL [24] = '{
      6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
      6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C,
      6'h31, 6'h32, 6'h34, 6'h38, 6'h1F, 6'h2F, 6'h37, 6'h3B};
   // ==================================================================
   // State types
   typedef enum logic [1:0] {CRX_LN_WAIT, CRX_LN_STOP, CRX_LN_PREP, CRX_LN_HS} crx_lane_st_type;
   typedef enum logic [2:0] {CRX_PS_IDLE, CRX_PS_HDR, CRX_PS_EVAL, CRX_PS_PAY, CRX_PS_CRC,
                             CRX_PS_DONE} crx_prs_st_type;
endpackage : crx_pkg

// [common/crx_hdr_if.sv]
// Header bundle between the packet parser and the header corrector.
// Assumes both ends sit in the link byte clock domain.
`timescale 1ns/10ps
`default_nettype none
interface crx_hdr_if;
   logic [31:0] hdr;
   logic [1:0]  vc;
   logic [5:0]  dt;
   logic [15:0] wc;
   logic        corr;
   logic        dbl;
   modport calc (input hdr, output vc, dt, wc, corr, dbl);
   modport user (output hdr, input vc, dt, wc, corr, dbl);
endinterface : crx_hdr_if
`default_nettype wire

// [design/crx_lane_fsm.sv]
// Low-power state tracker of one lane, clock lane or data lane alike.
// Assumes the line state pins are asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none
module crx_lane_fsm
   import crx_pkg::*;
(
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic lp_p,
   input  wire logic lp_n,
   output logic      hs_on,
   output logic      term_en
);
   logic [1:0]      lp_meta_reg;
   logic [1:0]      lp_s_reg;
   crx_lane_st_type st_reg;
   crx_lane_st_type st_next;

   // ==================================================================
   // Two-flop synchroniser for the line state.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lp_meta_reg <= CRX_LP00;
         lp_s_reg    <= CRX_LP00;
      end else begin
         lp_meta_reg <= {lp_p, lp_n};
         lp_s_reg    <= lp_meta_reg;
      end
   end

   // ==================================================================
   // Escape entry is not decoded, so a line state of 10 in stop or prepare drops the lane to wait.
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         CRX_LN_WAIT: if (lp_s_reg == CRX_LP11) st_next = CRX_LN_STOP;
         CRX_LN_STOP: begin
            if (lp_s_reg == CRX_LP01) st_next = CRX_LN_PREP;
            else if (lp_s_reg != CRX_LP11) st_next = CRX_LN_WAIT;
         end
         CRX_LN_PREP: begin
            if (lp_s_reg == CRX_LP00) st_next = CRX_LN_HS;
            else if (lp_s_reg == CRX_LP11) st_next = CRX_LN_STOP;
            else if (lp_s_reg != CRX_LP01) st_next = CRX_LN_WAIT;
         end
         default: if (lp_s_reg == CRX_LP11) st_next = CRX_LN_STOP;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) st_reg <= CRX_LN_WAIT;
      else st_reg <= st_next;
   end

   // Termination only while a burst is on; the lane is never driven.
   assign hs_on   = (st_reg == CRX_LN_HS);
   assign term_en = hs_on;

   sequence s_entry;
      lp_s_reg == CRX_LP11 ##1 lp_s_reg == CRX_LP01 ##1 lp_s_reg == CRX_LP00;
   endsequence

   AST_ENTRY: assert property (@(posedge clock) disable iff (sys_rst)
      s_entry |=> hs_on) else $error("Entry sequence did not reach high speed.");
   AST_STOP_EXIT: assert property (@(posedge clock) disable iff (sys_rst)
      hs_on && lp_s_reg == CRX_LP11 |=> !hs_on) else $error("Stop state did not end burst.");
   AST_TERM: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(term_en) |-> $past(lp_s_reg) == CRX_LP00) else $error("Termination without LP-00.");
endmodule : crx_lane_fsm
`default_nettype wire

// [design/crx_hdr_ecc.sv]
// Packet header corrector: single-bit repair, double-bit detection.
// Assumes a combinational path; the parser registers the header first.
`timescale 1ns/10ps
`default_nettype none
module crx_hdr_ecc
   import crx_pkg::*;
(
   crx_hdr_if.calc bus
);
   logic [5:0]  syn;
   logic [23:0] fix;
   logic        hit;

   // ==================================================================
   // Syndrome is recomputed parity against the received parity byte.
   always_comb begin
      syn = bus.hdr[29:24];
      fix = bus.hdr[23:0];
      hit = 1'b0;
      for (int i = 0; i < 24; i++) begin
         if (bus.hdr[i]) syn = syn ^ CRX_ECC_COL[i];
      end
      for (int i = 0; i < 24; i++) begin
         if (syn == CRX_ECC_COL[i]) begin
            fix[i] = ~fix[i];
            hit    = 1'b1;
         end
      end
      // A lone syndrome bit is an error in the parity byte itself.
      bus.corr = (syn != 6'h00) && (hit || $countones(syn) == 1);
      bus.dbl  = (syn != 6'h00) && !bus.corr;
      bus.vc   = fix[7:6];
      bus.dt   = fix[5:0];
      bus.wc   = fix[23:8];
   end
endmodule : crx_hdr_ecc
`default_nettype wire

// [design/crx_receiver.sv]
// Camera lane receiver: lane state tracking, packet parsing, error status.
// Assumes byte-aligned lane data on rx_byte_clk, lane 0 carrying the first byte.
//
// Notes on behaviour
// - Device only receives; lanes are never driven back.
// - Escape mode unsupported; escape line states are not decoded.
// - A lane is in control or high-speed; bursts start and end at LP-11.
// - Entry into high speed is LP-11, then LP-01, then LP-00.
// - After entry a lane stays high speed until LP-11 returns.
// - Termination enable is high during high speed; LP-00 is expected.
// - Clock lane uses the same low-power and high-speed handling.
// - A configuration input selects continuous or non-continuous clock.
// - Continuous clock mode treats the clock lane as always high speed.
// - One, two or four data lanes; bytes reassembled across lanes.
// - Data type 0x00 to 0x0F marks a 32-bit short packet.
// - Long header is identifier, 16-bit word count, ECC byte.
// - Identifier splits into virtual channel and data type, passed on.
// - Payload is exactly word-count bytes of eight bits.
// - A 16-bit checksum over the payload follows it.
// - Header ECC corrects single-bit and detects double-bit errors.
// - Short packets are sync markers; long packets carry data.
// - ECC error sets status; alarm output gated by an enable.
// - Payload checksum mismatch sets the checksum error status.
// - Start-of-transmission and sync errors are reported as status.
`timescale 1ns/10ps
`default_nettype none
module crx_receiver
   import crx_pkg::*;
#(
   parameter int LANES = 4
)(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        rx_byte_clk,
   input  wire logic        clk_cont_mode,
   input  wire logic [1:0]  lane_cfg,
   input  wire logic        alarm_en,
   input  wire logic        status_clear,
   input  wire logic        clk_lp_p,
   input  wire logic        clk_lp_n,
   input  wire logic [3:0]  dat_lp_p,
   input  wire logic [3:0]  dat_lp_n,
   input  wire logic [31:0] hs_byte,
   input  wire logic        hs_byte_valid,
   output logic             clk_term_en,
   output logic [3:0]       dat_term_en,
   output logic             pkt_valid,
   output logic             pkt_start,
   output logic             pkt_end,
   output logic             pkt_err,
   output logic [1:0]       pkt_vc,
   output logic [5:0]       pkt_dt,
   output logic [15:0]      pkt_wc,
   output logic [31:0]      pkt_data,
   output logic [3:0]       pkt_keep,
   output logic [4:0]       err_status,
   output logic             ecc_alarm
);
   initial begin
      if (LANES != 4) $error("crx_receiver supports a four-lane datapath only.");
   end

   // ==================================================================
   // Lane state trackers in the system clock domain
   logic       clk_fsm_hs;
   logic       clk_fsm_term;
   logic       clk_ok;
   logic [3:0] dat_hs;

   crx_lane_fsm u_clk_lane (
      .clock   (clock),
      .sys_rst (sys_rst),
      .lp_p    (clk_lp_p),
      .lp_n    (clk_lp_n),
      .hs_on   (clk_fsm_hs),
      .term_en (clk_fsm_term)
   );

   for (genvar g = 0; g < 4; g++) begin : g_lane
      crx_lane_fsm u_dat_lane (
         .clock   (clock),
         .sys_rst (sys_rst),
         .lp_p    (dat_lp_p[g]),
         .lp_n    (dat_lp_n[g]),
         .hs_on   (dat_hs[g]),
         .term_en (dat_term_en[g])
      );
   end

   // A continuous clock needs no low-power exit between bursts.
   assign clk_ok      = clk_cont_mode | clk_fsm_hs;
   assign clk_term_en = clk_ok;

   // ==================================================================
   // Byte-domain reset release and level crossings
   logic       brst_meta_reg;
   logic       brst_reg;
   logic [6:0] lvl_meta_reg;
   logic [6:0] lvl_sync_reg;

   always_ff @(posedge rx_byte_clk or posedge sys_rst) begin
      if (sys_rst) begin
         brst_meta_reg <= 1'b1;
         brst_reg      <= 1'b1;
      end else begin
         brst_meta_reg <= 1'b0;
         brst_reg      <= brst_meta_reg;
      end
   end

   // Lane configuration is treated as a slow level and synchronised too.
   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) begin
         lvl_meta_reg <= 7'h00;
         lvl_sync_reg <= 7'h00;
      end else begin
         lvl_meta_reg <= {lane_cfg, clk_ok, dat_hs};
         lvl_sync_reg <= lvl_meta_reg;
      end
   end

   function automatic logic [3:0] lane_mask(input logic [1:0] cfg);
      if (cfg == CRX_CFG_1LANE) return 4'h1;
      else if (cfg == CRX_CFG_2LANE) return 4'h3;
      else return 4'hF;
   endfunction : lane_mask

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRX_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   logic [3:0] act_mask;
   logic       burst;

   assign act_mask = lane_mask(lvl_sync_reg[6:5]);
   assign burst    = lvl_sync_reg[4] && ((lvl_sync_reg[3:0] & act_mask) == act_mask);

   // ==================================================================
   // Packet parser, stepping byte by byte across the active lanes
   crx_hdr_if hdr_bus ();
   crx_hdr_ecc u_ecc (.bus(hdr_bus.calc));

   crx_prs_st_type prs_st_reg;
   crx_prs_st_type prs_st_next;
   logic [15:0]    cnt_reg;
   logic [15:0]    cnt_next;
   logic [15:0]    crc_reg;
   logic [15:0]    crc_next;
   logic [15:0]    crc_rx_reg;
   logic [15:0]    crc_rx_next;
   logic [31:0]    hdr_reg;
   logic [31:0]    hdr_next;
   logic [1:0]     vc_reg;
   logic [5:0]     dt_reg;
   logic [15:0]    wc_reg;
   logic [31:0]    beat_data;
   logic [3:0]     beat_keep;
   logic           beat_start;
   logic           beat_end;
   logic           beat_err;
   logic [4:0]     ev;
   logic [7:0]     b;

   assign hdr_bus.hdr = hdr_reg;

   always_comb begin
      prs_st_next = prs_st_reg;
      cnt_next    = cnt_reg;
      crc_next    = crc_reg;
      crc_rx_next = crc_rx_reg;
      hdr_next    = hdr_reg;
      beat_data   = 32'h0000_0000;
      beat_keep   = 4'h0;
      beat_start  = 1'b0;
      beat_end    = 1'b0;
      beat_err    = 1'b0;
      ev          = 5'h00;
      b           = 8'h00;
      if (!burst) begin
         prs_st_next = CRX_PS_IDLE;
      end else if (hs_byte_valid) begin
         if (prs_st_reg == CRX_PS_IDLE) begin
            // First byte of every active lane must be the sync pattern.
            prs_st_next = CRX_PS_HDR;
            cnt_next    = 16'h0000;
            for (int k = 0; k < 4; k++) begin
               if (act_mask[k] && hs_byte[k*8 +: 8] != CRX_SYNC_BYTE) begin
                  if ($countones(hs_byte[k*8 +: 8] ^ CRX_SYNC_BYTE) == 1)
                     ev[CRX_ST_SOT] = 1'b1;
                  else
                     ev[CRX_ST_SOT_SYNC] = 1'b1;
               end
            end
            if (ev[CRX_ST_SOT_SYNC]) prs_st_next = CRX_PS_DONE;
         end else begin
            if (prs_st_reg == CRX_PS_EVAL) begin
               beat_start = 1'b1;
               ev[CRX_ST_ECC_CORR] = hdr_bus.corr;
               cnt_next = 16'h0000;
               crc_next = CRX_CRC_INIT;
               if (hdr_bus.dbl) begin
                  ev[CRX_ST_ECC_DBL] = 1'b1;
                  beat_end    = 1'b1;
                  beat_err    = 1'b1;
                  prs_st_next = CRX_PS_DONE;
               end else if (hdr_bus.dt <= CRX_SHORT_DT_MAX) begin
                  beat_end    = 1'b1;
                  prs_st_next = CRX_PS_DONE;
               end else if (hdr_bus.wc == 16'h0000) begin
                  prs_st_next = CRX_PS_CRC;
               end else begin
                  prs_st_next = CRX_PS_PAY;
               end
            end
            for (int k = 0; k < 4; k++) begin
               b = hs_byte[k*8 +: 8];
               if (act_mask[k]) begin
                  case (prs_st_next)
                     CRX_PS_HDR: begin
                        hdr_next[{cnt_next[1:0], 3'b000} +: 8] = b;
                        cnt_next = cnt_next + 16'h0001;
                        if (cnt_next == CRX_HDR_BYTES) prs_st_next = CRX_PS_EVAL;
                     end
                     CRX_PS_PAY: begin
                        beat_data[k*8 +: 8] = b;
                        beat_keep[k] = 1'b1;
                        crc_next = crc_byte(crc_next, b);
                        cnt_next = cnt_next + 16'h0001;
                        if (cnt_next == hdr_bus.wc) begin
                           cnt_next    = 16'h0000;
                           prs_st_next = CRX_PS_CRC;
                        end
                     end
                     CRX_PS_CRC: begin
                        crc_rx_next[{cnt_next[0], 3'b000} +: 8] = b;
                        cnt_next = cnt_next + 16'h0001;
                        if (cnt_next == CRX_CRC_BYTES) begin
                           beat_end    = 1'b1;
                           prs_st_next = CRX_PS_DONE;
                           if (crc_rx_next != crc_next) begin
                              ev[CRX_ST_CRC] = 1'b1;
                              beat_err = 1'b1;
                           end
                        end
                     end
                     default: begin
                        b = 8'h00;
                     end
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) begin
         prs_st_reg <= CRX_PS_IDLE;
         cnt_reg    <= 16'h0000;
         crc_reg    <= CRX_CRC_INIT;
         crc_rx_reg <= 16'h0000;
         hdr_reg    <= 32'h0000_0000;
      end else begin
         prs_st_reg <= prs_st_next;
         cnt_reg    <= cnt_next;
         crc_reg    <= crc_next;
         crc_rx_reg <= crc_rx_next;
         hdr_reg    <= hdr_next;
      end
   end

   // Corrected header fields are held for the payload beats that follow.
   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) begin
         vc_reg <= 2'h0;
         dt_reg <= 6'h00;
         wc_reg <= 16'h0000;
      end else if (beat_start) begin
         vc_reg <= hdr_bus.vc;
         dt_reg <= hdr_bus.dt;
         wc_reg <= hdr_bus.wc;
      end
   end

   // ==================================================================
   // Output stream, registered, one beat per byte group
   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) begin
         pkt_valid <= 1'b0;
         pkt_start <= 1'b0;
         pkt_end   <= 1'b0;
         pkt_err   <= 1'b0;
         pkt_vc    <= 2'h0;
         pkt_dt    <= 6'h00;
         pkt_wc    <= 16'h0000;
         pkt_data  <= 32'h0000_0000;
         pkt_keep  <= 4'h0;
      end else begin
         pkt_valid <= beat_start | beat_end | (|beat_keep);
         pkt_start <= beat_start;
         pkt_end   <= beat_end;
         pkt_err   <= beat_err;
         pkt_vc    <= beat_start ? hdr_bus.vc : vc_reg;
         pkt_dt    <= beat_start ? hdr_bus.dt : dt_reg;
         pkt_wc    <= beat_start ? hdr_bus.wc : wc_reg;
         pkt_data  <= beat_data;
         pkt_keep  <= beat_keep;
      end
   end

   // ==================================================================
   // Error events cross by toggle; a flip means one event occurred.
   logic [4:0] tog_reg;
   logic [4:0] tog_meta_reg;
   logic [4:0] tog_sync_reg;
   logic [4:0] tog_prev_reg;

   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) tog_reg <= 5'h00;
      else tog_reg <= tog_reg ^ ev;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tog_meta_reg <= 5'h00;
         tog_sync_reg <= 5'h00;
         tog_prev_reg <= 5'h00;
      end else begin
         tog_meta_reg <= tog_reg;
         tog_sync_reg <= tog_meta_reg;
         tog_prev_reg <= tog_sync_reg;
      end
   end

   // Sticky status; a new event in the clearing cycle survives the clear.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) err_status <= 5'h00;
      else err_status <= (err_status & ~{CRX_ST_BITS{status_clear}})
                         | (tog_sync_reg ^ tog_prev_reg);
   end

   assign ecc_alarm = alarm_en & (err_status[CRX_ST_ECC_CORR] | err_status[CRX_ST_ECC_DBL]);

   // ==================================================================
   // Checks
   logic [15:0] pay_seen_reg;
   logic [15:0] pay_total;

   assign pay_total = (pkt_start ? 16'h0000 : pay_seen_reg) + 16'($countones(pkt_keep));

   always_ff @(posedge rx_byte_clk or posedge brst_reg) begin
      if (brst_reg) pay_seen_reg <= 16'h0000;
      else if (pkt_valid) pay_seen_reg <= pay_total;
   end

   AST_SHORT: assert property (@(posedge rx_byte_clk) disable iff (brst_reg)
      pkt_valid && pkt_start && !pkt_err && pkt_dt <= CRX_SHORT_DT_MAX
      |-> pkt_end && pkt_keep == 4'h0) else $error("Short packet not closed at once.");
   AST_DISCARD: assert property (@(posedge rx_byte_clk) disable iff (brst_reg)
      !burst |=> prs_st_reg == CRX_PS_IDLE) else $error("Partial packet kept after burst.");
   AST_PAYLEN: assert property (@(posedge rx_byte_clk) disable iff (brst_reg)
      pkt_valid && pkt_end && !pkt_err && pkt_dt > CRX_SHORT_DT_MAX
      |-> pay_total == pkt_wc) else $error("Payload length differs from word count.");
   AST_STICKY: assert property (@(posedge clock) disable iff (sys_rst)
      err_status[CRX_ST_CRC] && !status_clear |=> err_status[CRX_ST_CRC])
      else $error("Checksum status lost without a clear.");
   AST_ALARM: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(err_status[CRX_ST_ECC_DBL]) && alarm_en |-> ecc_alarm)
      else $error("Enabled alarm missing on ECC error.");
   AST_CONT: assert property (@(posedge clock) disable iff (sys_rst)
      clk_cont_mode |-> clk_term_en) else $error("Continuous clock lane not high speed.");
endmodule : crx_receiver
`default_nettype wire

// [testbench/crx_sensor_model.sv]
// Image sensor model: lane line states, gated byte clock, lane bytes.
// Assumes the receiver samples whatever it is given.
`timescale 1ns/10ps
`default_nettype none
module crx_sensor_model
   import crx_pkg::*;
(
   output var logic        rx_byte_clk,
   output var logic        clk_lp_p,
   output var logic        clk_lp_n,
   output var logic [3:0]  dat_lp_p,
   output var logic [3:0]  dat_lp_n,
   output var logic [31:0] hs_byte,
   output var logic        hs_byte_valid
);
   logic run;
   // =================================================================
   // The byte clock stands still outside bursts, as a gated one does.
   initial begin
      run = 1'b0;
      rx_byte_clk = 1'b0;
      hs_byte = 32'h5A5A5A5A;
      hs_byte_valid = 1'b0;
      set_lp(CRX_LP11);
   end
   always #7.5 if (run) rx_byte_clk = ~rx_byte_clk;
   // All lanes, clock lane too, pass through the same line states.
   task automatic set_lp(input logic [1:0] s);
      {clk_lp_p, clk_lp_n} = s;
      dat_lp_p = {4{s[1]}};
      dat_lp_n = {4{s[0]}};
   endtask : set_lp
   // One burst: entry, sync, groups of n bytes, then stop state again.
   // Idle bytes are inverted so a stale value never looks valid.
   task automatic burst(input int n, input bit bad, input logic [7:0] sy,
                        input logic [7:0] q[$]);
      int i;
      set_lp(CRX_LP11);
      #40 set_lp(bad ? 2'h2 : CRX_LP01);
      #40 set_lp(CRX_LP00);
      #60 run = 1'b1;
      repeat (4) @(negedge rx_byte_clk);
      for (i = 0; i < n; i++) q.push_front(sy);
      // One trailing idle group lets the parser judge a header that ends a burst.
      for (i = 0; i < n; i++) q.push_back(8'h00);
      while (q.size() > 0) begin
         hs_byte = ~hs_byte;
         for (i = 0; i < n; i++) hs_byte[8*i+:8] = q.size() ? q.pop_front() : 8'h00;
         hs_byte_valid = 1'b1;
         @(negedge rx_byte_clk);
      end
      hs_byte_valid = 1'b0;
      hs_byte = ~hs_byte;
      repeat (6) @(negedge rx_byte_clk);
      // The byte clock runs on past the stop state so the receiver sees the burst end.
      set_lp(CRX_LP11);
      repeat (8) @(negedge rx_byte_clk);
      run = 1'b0;
      #60;
   endtask : burst
endmodule : crx_sensor_model
`default_nettype wire

// [testbench/crx_receiver_tb_top.sv]
// Bench of the camera lane receiver with a sensor model on the lanes.
// Assumes four lanes are built and the byte clock runs only in bursts.
`timescale 1ns/10ps
`default_nettype none
module crx_receiver_tb_top;
   import crx_pkg::*;
   logic        clock, sys_rst, clk_cont_mode, alarm_en, status_clear, saw_hs;
   logic [1:0]  lane_cfg;
   logic [62:0] beats[$];
   int          err_count, checked;
   wire         rx_byte_clk, clk_lp_p, clk_lp_n, hs_byte_valid, clk_term_en;
   wire         pkt_valid, pkt_start, pkt_end, pkt_err, ecc_alarm;
   wire [3:0]   dat_lp_p, dat_lp_n, dat_term_en, pkt_keep;
   wire [31:0]  hs_byte, pkt_data;
   wire [1:0]   pkt_vc;
   wire [5:0]   pkt_dt;
   wire [15:0]  pkt_wc;
   wire [4:0]   err_status;
   crx_receiver #(.LANES(4)) DUT (.clock, .sys_rst, .rx_byte_clk, .clk_cont_mode, .lane_cfg,
      .alarm_en, .status_clear, .clk_lp_p, .clk_lp_n, .dat_lp_p, .dat_lp_n, .hs_byte,
      .hs_byte_valid, .clk_term_en, .dat_term_en, .pkt_valid, .pkt_start, .pkt_end,
      .pkt_err, .pkt_vc, .pkt_dt, .pkt_wc, .pkt_data, .pkt_keep, .err_status, .ecc_alarm);
   crx_sensor_model SNS (.rx_byte_clk, .clk_lp_p, .clk_lp_n, .dat_lp_p, .dat_lp_n,
      .hs_byte, .hs_byte_valid);
   // =================================================================
   // Beats are taken mid-cycle, away from the edge that launches them.
   always #5 clock = ~clock;
   always @(negedge rx_byte_clk) if (pkt_valid === 1'b1) beats.push_back({pkt_start, pkt_end,
      pkt_err, pkt_vc, pkt_dt, pkt_keep, pkt_wc, pkt_data});
   always @(negedge clock) if (dat_term_en === 4'hF && clk_term_en === 1'b1) saw_hs = 1'b1;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] ecc(input logic [23:0] d);
      ecc = 8'h00;
      for (int i = 0; i < 24; i++) if (d[i]) ecc[5:0] ^= CRX_ECC_COL[i];
   endfunction : ecc
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      crc = CRX_CRC_INIT;
      foreach (q[k]) for (int b = 0; b < 8; b++)
         crc = (crc >> 1) ^ ((crc[0] ^ q[k][b]) ? CRX_CRC_POLY : 16'h0000);
   endfunction : crc
   // Clears status, builds one packet, sends it and lets status settle.
   task automatic shot(input int n, input bit bad, input logic [7:0] sy, input logic [23:0] hd,
                       input int np, input logic [23:0] fl, input logic [15:0] cb);
      logic [7:0]  q[$];
      logic [7:0]  p[$];
      logic [15:0] c;
      @(negedge clock) status_clear = 1'b1;
      lane_cfg = (n == 4) ? 2'h2 : 2'(n - 1);
      @(negedge clock) status_clear = 1'b0;
      for (int k = 0; k < np; k++) p.push_back(8'hA0 + 8'(k));
      c = crc(p) ^ cb;
      q = {hd[7:0] ^ fl[7:0], hd[15:8] ^ fl[15:8], hd[23:16] ^ fl[23:16], ecc(hd)};
      q = {q, p};
      if (hd[5:0] > CRX_SHORT_DT_MAX && np == int'(hd[23:8])) q = {q, c[7:0], c[15:8]};
      beats = {};
      saw_hs = 1'b0;
      SNS.burst(n, bad, sy, q);
      repeat (8) @(negedge clock);
   endtask : shot
   task automatic t_bad;
      shot(4, 1, CRX_SYNC_BYTE, {16'h1234, 8'h40}, 0, 0, 0);
      chk(saw_hs, 0);
      chk(beats.size(), 0);
   endtask : t_bad
   task automatic t_short;
      int         nl[3] = '{1, 2, 4};
      logic [5:0] dt[3] = '{6'h00, 6'h0F, 6'h08};
      for (int i = 0; i < 3; i++) begin
         shot(nl[i], 0, CRX_SYNC_BYTE, {16'h1234, 2'h1, dt[i]}, 0, 0, 0);
         chk(beats[0][62:32], {3'b110, 2'h1, dt[i], 4'h0, 16'h1234});
         chk(saw_hs, 1);
         chk({dat_term_en, clk_term_en}, 0);
      end
   endtask : t_short
   task automatic t_long;
      for (int i = 0; i < 2; i++) begin
         shot(4, 0, CRX_SYNC_BYTE, {16'h0004, 8'h90}, 4, i ? 24'h000200 : 0, 0);
         chk(beats.size(), 2);
         chk(beats[0], {3'b100, 8'h90, 4'hF, 16'h0004, 32'hA3A2A1A0});
         chk(beats[1][61:60], 2'b10);
         chk({err_status[0], ecc_alarm}, {2{i[0]}});
      end
   endtask : t_long
   task automatic t_err;
      logic [7:0]  sy[4] = '{8'hB8, 8'hB8, 8'hB9, 8'h00};
      logic [4:0]  es[4] = '{5'h04, 5'h02, 5'h08, 5'h10};
      for (int i = 0; i < 4; i++) begin
         @(negedge clock) alarm_en = (i != 1);
         shot(4, 0, sy[i], {16'h0004, 8'h90}, 4, (i == 1) ? 24'h000300 : 0, i == 0);
         chk({err_status, ecc_alarm}, {es[i], 1'b0});
         if (i == 0) chk(beats[1][60], 1);
      end
   endtask : t_err
   task automatic t_abort;
      shot(4, 0, CRX_SYNC_BYTE, {16'h0008, 8'h90}, 4, 0, 0);
      foreach (beats[k]) chk(beats[k][61], 0);
      chk({err_status, dat_term_en}, 0);
   endtask : t_abort
   task automatic complete_run;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Continuous clock mode is seen at idle before any burst.
   initial begin
      {clock, sys_rst, clk_cont_mode, alarm_en, status_clear, lane_cfg} = 7'h3C;
      {err_count, checked, saw_hs} = 0;
      repeat (16) @(posedge clock);
      @(negedge clock) sys_rst = 1'b0;
      repeat (10) @(negedge clock);
      chk({clk_term_en, dat_term_en}, 5'h10);
      clk_cont_mode = 1'b0;
      t_bad();
      t_short();
      t_long();
      t_err();
      t_abort();
      complete_run();
   end
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
endmodule : crx_receiver_tb_top
`default_nettype wire
